// ### logic/dbesb_pkg.sv
// Functional notes
// - Undervoltage on analog supply or software reset sets register-reset event latch bit 0.
// - That event disables both regulators, restores register defaults, then runs startup.
// - Power-good event per channel latches bit 6 (channel one) or bit 2 (zero).
// - Short latch bit 5/1 only after output below threshold over 1 ms.
// - Active current limit latches bit 4 (channel one) or bit 0 (channel zero).
// - Event latches hold until host writes one there; only addressed bits clear; reset zero.
// - Top status bit 7 follows the power-good output pin level.
// - Top status bit 4 reads zero while sync clock valid, one otherwise.
// - Top status bit 3 shows thermal shutdown live.
// - Top status bit 2 shows thermal warning comparator live.
// - Top status bit 1 shows input overvoltage live.
// - Channel status bits 7 and 3 show each regulator enabled.
// - Channel status bits 6 and 2 show raw output invalid, one meaning invalid.
// - Channel status bits 4 and 0 show raw current limit active.
// - Summary channel-event bit 5 at 0x19 clears itself when channel latches are all zero.
// - Writing one to command bit 0 resets registers and serial interface; bit self-clears.
package dbesb_pkg;

    // Register offsets
    localparam logic [7:0] RESET_CMD_OFFSET    = 8'h18;
    localparam logic [7:0] TOP_EVENT_ONE_OFF   = 8'h19;
    localparam logic [7:0] TOP_EVENT_TWO_OFF   = 8'h1a;
    localparam logic [7:0] CHAN_EVENT_OFFSET   = 8'h1b;
    localparam logic [7:0] TOP_STATUS_OFFSET   = 8'h1d;
    localparam logic [7:0] CHAN_STATUS_OFFSET  = 8'h1e;

    // Field positions
    localparam int SOFTWARE_RESET_COMMAND_BIT       = 0;
    localparam int REG_RESET_EVT_BIT  = 0;
    localparam int CHAN_SUMMARY_BIT   = 5;
    localparam int PG_PIN_BIT         = 7;
    localparam int SYNC_INVALID_BIT   = 4;
    localparam int THERM_SD_BIT       = 3;
    localparam int THERM_WARN_BIT     = 2;
    localparam int OVERVOLT_BIT       = 1;
    localparam int CH1_ENABLED_BIT    = 7;
    localparam int CH1_INVALID_BIT    = 6;
    localparam int CH1_SHORT_BIT      = 5;
    localparam int CH1_ILIM_BIT       = 4;
    localparam int CH0_ENABLED_BIT    = 3;
    localparam int CH0_INVALID_BIT    = 2;
    localparam int CH0_SHORT_BIT      = 1;
    localparam int CH0_ILIM_BIT       = 0;

    // Reset values
    localparam logic [7:0] EVENT_RESET_VALUE  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // Timing: short-circuit qualification time
    localparam int SHORT_TIME_US  = 1000;
    localparam int CLK_FREQ_KHZ   = 10000;
    localparam int SHORT_CYCLES   = (SHORT_TIME_US * CLK_FREQ_KHZ) / 1000;

    // Reset sequencer states
    typedef enum logic [1:0] {
        DBESB_RUN,
        DBESB_HOLD,
        DBESB_START
    } dbesb_rst_state_t;

endpackage : dbesb_pkg

// ### logic/dbesb_event_status_bank.sv
`timescale 1ns/100ps
module dbesb_event_status_bank #(
    parameter int SHORT_CYCLES = dbesb_pkg::SHORT_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       analog_supply_uv_i,
    input  wire logic       power_good_output_i,
    input  wire logic       sync_clock_invalid_i,
    input  wire logic       thermal_shutdown_i,
    input  wire logic       thermal_warning_i,
    input  wire logic       input_overvoltage_i,
    input  wire logic [1:0] ch_enabled_i,
    input  wire logic [1:0] ch_output_invalid_i,
    input  wire logic [1:0] ch_current_limit_i,
    input  wire logic [1:0] ch_below_short_i,
    output logic            regulators_disable_o,
    output logic            register_reset_o,
    output logic            serial_if_reset_o,
    output logic            startup_request_o
);

    localparam int NSYNC = 14;
    localparam int CW    = $clog2(SHORT_CYCLES + 2);

    // Address match shared by read and write decode
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
        addr_is = (addr == off);
    endfunction : addr_is

    logic [NSYNC-1:0]                  sync1_q;
    logic [NSYNC-1:0]                  sync2_q;
    logic                              uv_s;
    logic                              pg_pin_s;
    logic                              sync_inv_s;
    logic                              tsd_s;
    logic                              twarn_s;
    logic                              ovp_s;
    logic [1:0]                        en_s;
    logic [1:0]                        inv_s;
    logic [1:0]                        ilim_s;
    logic [1:0]                        below_s;
    logic [1:0]                        inv_prev_q;
    logic [1:0]                        pg_evt;
    logic [1:0]                        short_evt;
    logic [1:0][CW-1:0]                short_cnt_q;
    logic [7:0]                        chan_evt_q;
    logic [7:0]                        chan_set;
    logic [7:0]                        chan_clr;
    logic                              reg_reset_evt_q;
    logic                              software_reset_command_req;
    logic                              top_two_clr;
    dbesb_pkg::dbesb_rst_state_t       state_q;
    dbesb_pkg::dbesb_rst_state_t       state_d;
    logic [7:0]                        top_one_val;
    logic [7:0]                        top_stat_val;
    logic [7:0]                        chan_stat_val;
    logic [7:0]                        read_val;
    logic [7:0]                        rdata_q;

    // Two-flop synchronisers for all analog and pin levels
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {ch_below_short_i, ch_current_limit_i, ch_output_invalid_i, ch_enabled_i,
                        input_overvoltage_i, thermal_warning_i, thermal_shutdown_i,
                        sync_clock_invalid_i, power_good_output_i, analog_supply_uv_i};
            sync2_q <= sync1_q;
        end
    end

    assign uv_s       = sync2_q[0];
    assign pg_pin_s   = sync2_q[1];
    assign sync_inv_s = sync2_q[2];
    assign tsd_s      = sync2_q[3];
    assign twarn_s    = sync2_q[4];
    assign ovp_s      = sync2_q[5];
    assign en_s       = sync2_q[7:6];
    assign inv_s      = sync2_q[9:8];
    assign ilim_s     = sync2_q[11:10];
    assign below_s    = sync2_q[13:12];

    // Previous validity level, to see power-good transitions
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inv_prev_q <= '0;
        end else begin
            inv_prev_q <= inv_s;
        end
    end

    // Per-channel event detection
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        assign pg_evt[ch]    = inv_s[ch] ^ inv_prev_q[ch];
        assign short_evt[ch] = below_s[ch] && (short_cnt_q[ch] == CW'(SHORT_CYCLES));

        // Counts consecutive cycles below the short threshold, saturating
        always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                short_cnt_q[ch] <= '0;
            end else if (!below_s[ch]) begin
                short_cnt_q[ch] <= '0;
            end else if (short_cnt_q[ch] <= CW'(SHORT_CYCLES)) begin
                short_cnt_q[ch] <= short_cnt_q[ch] + CW'(1);
            end
        end
    end

    // Host write decode; only writes with data bit set clear anything
    assign software_reset_command_req = reg_wr_i && addr_is(reg_addr_i, dbesb_pkg::RESET_CMD_OFFSET)
                          && reg_wdata_i[dbesb_pkg::SOFTWARE_RESET_COMMAND_BIT];
    assign top_two_clr  = reg_wr_i && addr_is(reg_addr_i, dbesb_pkg::TOP_EVENT_TWO_OFF)
                          && reg_wdata_i[dbesb_pkg::REG_RESET_EVT_BIT];

    // Set and clear vectors of the channel event latches
    always_comb begin
        chan_set = '0;
        chan_set[dbesb_pkg::CH1_INVALID_BIT] = pg_evt[1];
        chan_set[dbesb_pkg::CH0_INVALID_BIT] = pg_evt[0];
        chan_set[dbesb_pkg::CH1_SHORT_BIT]   = short_evt[1];
        chan_set[dbesb_pkg::CH0_SHORT_BIT]   = short_evt[0];
        chan_set[dbesb_pkg::CH1_ILIM_BIT]    = ilim_s[1];
        chan_set[dbesb_pkg::CH0_ILIM_BIT]    = ilim_s[0];
        chan_clr = '0;
        if (reg_wr_i && addr_is(reg_addr_i, dbesb_pkg::CHAN_EVENT_OFFSET)) begin
            chan_clr = reg_wdata_i & 8'h77;
        end
    end

    // Reset sequencer: hold while undervoltage persists, then request startup
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dbesb_pkg::DBESB_RUN: begin
                if (uv_s || software_reset_command_req) begin
                    state_d = dbesb_pkg::DBESB_HOLD;
                end
            end
            dbesb_pkg::DBESB_HOLD: begin
                if (!uv_s) begin
                    state_d = dbesb_pkg::DBESB_START;
                end
            end
            dbesb_pkg::DBESB_START: begin
                state_d = dbesb_pkg::DBESB_RUN;
            end
            default: begin
                state_d = dbesb_pkg::DBESB_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= dbesb_pkg::DBESB_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Sequencer outputs to the rest of the device
    assign regulators_disable_o = (state_q == dbesb_pkg::DBESB_HOLD);
    assign register_reset_o     = (state_q == dbesb_pkg::DBESB_HOLD);
    assign serial_if_reset_o    = (state_q == dbesb_pkg::DBESB_HOLD);
    assign startup_request_o    = (state_q == dbesb_pkg::DBESB_START);

    // Channel event latches; set beats clear, register reset wipes them
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chan_evt_q <= dbesb_pkg::EVENT_RESET_VALUE;
        end else if (state_q == dbesb_pkg::DBESB_HOLD) begin
            chan_evt_q <= dbesb_pkg::EVENT_RESET_VALUE;
        end else begin
            chan_evt_q <= (chan_evt_q & ~chan_clr) | chan_set;
        end
    end

    // Register-reset event latch, set once defaults are restored
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_reset_evt_q <= 1'b0;
        end else if (state_q == dbesb_pkg::DBESB_HOLD) begin
            reg_reset_evt_q <= 1'b0;
        end else if (state_q == dbesb_pkg::DBESB_START) begin
            reg_reset_evt_q <= 1'b1;
        end else if (top_two_clr) begin
            reg_reset_evt_q <= 1'b0;
        end
    end

    // Readback values built from live and latched state
    always_comb begin
        top_one_val = '0;
        top_one_val[dbesb_pkg::CHAN_SUMMARY_BIT] = |chan_evt_q;
        top_stat_val = '0;
        top_stat_val[dbesb_pkg::PG_PIN_BIT]       = pg_pin_s;
        top_stat_val[dbesb_pkg::SYNC_INVALID_BIT] = sync_inv_s;
        top_stat_val[dbesb_pkg::THERM_SD_BIT]     = tsd_s;
        top_stat_val[dbesb_pkg::THERM_WARN_BIT]   = twarn_s;
        top_stat_val[dbesb_pkg::OVERVOLT_BIT]     = ovp_s;
        chan_stat_val = '0;
        chan_stat_val[dbesb_pkg::CH1_ENABLED_BIT] = en_s[1];
        chan_stat_val[dbesb_pkg::CH0_ENABLED_BIT] = en_s[0];
        chan_stat_val[dbesb_pkg::CH1_INVALID_BIT] = inv_s[1];
        chan_stat_val[dbesb_pkg::CH0_INVALID_BIT] = inv_s[0];
        chan_stat_val[dbesb_pkg::CH1_ILIM_BIT]    = ilim_s[1];
        chan_stat_val[dbesb_pkg::CH0_ILIM_BIT]    = ilim_s[0];
    end

    // Read multiplexer; command register always reads back cleared
    always_comb begin
        read_val = dbesb_pkg::READ_UNMAPPED;
        if (addr_is(reg_addr_i, dbesb_pkg::TOP_EVENT_ONE_OFF)) begin
            read_val = top_one_val;
        end else if (addr_is(reg_addr_i, dbesb_pkg::TOP_EVENT_TWO_OFF)) begin
            read_val = {7'h00, reg_reset_evt_q};
        end else if (addr_is(reg_addr_i, dbesb_pkg::CHAN_EVENT_OFFSET)) begin
            read_val = chan_evt_q;
        end else if (addr_is(reg_addr_i, dbesb_pkg::TOP_STATUS_OFFSET)) begin
            read_val = top_stat_val;
        end else if (addr_is(reg_addr_i, dbesb_pkg::CHAN_STATUS_OFFSET)) begin
            read_val = chan_stat_val;
        end
    end

    // Read data register; reads touch nothing else
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= read_val;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule : dbesb_event_status_bank

// ### verif/dbesb_checker.sv
`timescale 1ns/100ps
module dbesb_checker #(
    parameter int SHORT_CYCLES = 8
) (
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       analog_supply_uv_i,
    input wire logic       power_good_output_i,
    input wire logic       sync_clock_invalid_i,
    input wire logic       thermal_shutdown_i,
    input wire logic       thermal_warning_i,
    input wire logic       input_overvoltage_i,
    input wire logic [1:0] ch_enabled_i,
    input wire logic [1:0] ch_output_invalid_i,
    input wire logic [1:0] ch_current_limit_i,
    input wire logic [1:0] ch_below_short_i,
    input wire logic       regulators_disable_o,
    input wire logic       register_reset_o,
    input wire logic       serial_if_reset_o,
    input wire logic       startup_request_o
);
    logic [7:0] top_live;
    logic [7:0] chan_live;
    // Expected live status words from the raw inputs
    assign top_live  = {power_good_output_i, 2'h0, sync_clock_invalid_i, thermal_shutdown_i, thermal_warning_i,
                        input_overvoltage_i, 1'h0};
    assign chan_live = {ch_enabled_i[1], ch_output_invalid_i[1], 1'h0, ch_current_limit_i[1],
                        ch_enabled_i[0], ch_output_invalid_i[0], 1'h0, ch_current_limit_i[0]};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Reads of settled status outside the reset sequence
    sequence s_top_rd;
        $stable(top_live)[*3] ##0 ($past(resetn_i, 4) && reg_rd_i && reg_addr_i == 8'h1d && !regulators_disable_o);
    endsequence
    sequence s_chan_rd;
        $stable(chan_live)[*3] ##0 ($past(resetn_i, 4) && reg_rd_i && reg_addr_i == 8'h1e && !regulators_disable_o);
    endsequence
    sequence s_hold_end;
        regulators_disable_o ##1 !regulators_disable_o;
    endsequence
    property p_top_stat;  s_top_rd |=> reg_rdata_o == $past(top_live); endproperty
    property p_chan_stat; s_chan_rd |=> reg_rdata_o == $past(chan_live); endproperty
    property p_start;     s_hold_end |-> startup_request_o ##1 !startup_request_o; endproperty
    property p_cause;     $rose(startup_request_o) |-> $past(regulators_disable_o); endproperty
    property p_tie;       register_reset_o == regulators_disable_o && serial_if_reset_o == regulators_disable_o;
    endproperty
    property p_sw_rst;
        reg_wr_i && reg_addr_i == 8'h18 && reg_wdata_i[0] && !startup_request_o && !regulators_disable_o
            |=> regulators_disable_o;
    endproperty
    property p_unmapped;
        reg_rd_i && !(reg_addr_i inside {[8'h19:8'h1b], 8'h1d, 8'h1e}) |=> reg_rdata_o == 8'h00;
    endproperty
    property p_rd_hold;   !reg_rd_i && !regulators_disable_o |=> $stable(reg_rdata_o); endproperty
    a_top_stat:  assert property (p_top_stat) else $error("top status read differs from inputs");
    a_chan_stat: assert property (p_chan_stat) else $error("channel status read differs");
    a_start:     assert property (p_start) else $error("no single startup pulse after hold");
    a_cause:     assert property (p_cause) else $error("startup without hold");
    a_tie:       assert property (p_tie) else $error("reset outputs disagree");
    a_sw_rst:    assert property (p_sw_rst) else $error("reset command ignored");
    a_unmapped:  assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_hold:   assert property (p_rd_hold) else $error("read data moved without read");
endmodule : dbesb_checker

bind dbesb_event_status_bank dbesb_checker #(.SHORT_CYCLES(SHORT_CYCLES)) u_chk (.*);

// ### verif/dbesb_host_model.sv
`timescale 1ns/100ps
module dbesb_host_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o
);
    // Idle bus at time zero
    initial begin
        reg_addr_o = 8'hff;
        reg_wdata_o = 8'hff;
        reg_wr_o = 1'h0;
        reg_rd_o = 1'h0;
    end
    // One write strobe; released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'h1;
        @(negedge core_clk_i);
        reg_wr_o <= 1'h0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr
    // One read strobe; data taken after the sampling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'h1;
        @(negedge core_clk_i);
        reg_rd_o <= 1'h0;
        reg_addr_o <= ~a;
        d = reg_rdata_i;
    endtask : rd
endmodule : dbesb_host_model

// ### verif/dual_buck_event_status_bank_tb.sv
`timescale 1ns/100ps
module dual_buck_event_status_bank_tb;
    logic       core_clk_i = 1'h0;
    logic       resetn_i = 1'h0;
    logic [7:0] addr, wdata, rdata, d, ev;
    logic       wr, rd, uv, pg, sync_bad, tsd, twarn, ovp, dis, rrst, srst, start;
    logic [1:0] en, inval, lim, short;
    int         mismatches = 0;
    int         tests_run = 0;
    // Free-running core clock
    always #50 core_clk_i = ~core_clk_i;
    dbesb_event_status_bank #(.SHORT_CYCLES(8)) dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .analog_supply_uv_i(uv),
        .power_good_output_i(pg), .sync_clock_invalid_i(sync_bad), .thermal_shutdown_i(tsd),
        .thermal_warning_i(twarn), .input_overvoltage_i(ovp), .ch_enabled_i(en),
        .ch_output_invalid_i(inval), .ch_current_limit_i(lim), .ch_below_short_i(short),
        .regulators_disable_o(dis), .register_reset_o(rrst), .serial_if_reset_o(srst),
        .startup_request_o(start));
    dbesb_host_model u_host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    // Compare and count
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk
    task rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rchk
    task idle(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : idle
    // Raise one event input of one channel for n cycles
    task pulse(input int k, input int c, input int n);
        case (k)
            0: lim[c] = 1'h1;
            1: short[c] = 1'h1;
            default: inval[c] = 1'h1;
        endcase
        idle(n);
        {lim, short, inval} = 6'h0;
    endtask : pulse
    function logic [7:0] top_exp();
        return {pg, 2'h0, sync_bad, tsd, twarn, ovp, 1'h0};
    endfunction : top_exp
    function logic [7:0] chan_exp();
        return {en[1], inval[1], 1'h0, lim[1], en[0], inval[0], 1'h0, lim[0]};
    endfunction : chan_exp
    task test_done();
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // Hang limit
    initial begin
        #1ms;
        mismatches++;
        test_done();
    end
    // Main sequence
    initial begin
        {uv, pg, sync_bad, tsd, twarn, ovp} = 6'h0;
        {en, inval, lim, short} = 8'h0;
        void'($urandom(32'h28035e8f));
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i) resetn_i = 1'h1;
        for (int i = 0; i < 3; i++) rchk(8'h19 + 8'(i), 8'h00);
        u_host.wr(8'h1d, 8'hff);
        u_host.wr(8'h1e, 8'hff);
        rchk(8'h1d, 8'h00);
        rchk(8'h1e, 8'h00);
        rchk(8'h05, 8'h00);
        repeat (20) begin
            {pg, sync_bad, tsd, twarn, ovp} = 5'($urandom);
            {en, lim, inval} = 6'($urandom);
            idle(3);
            rchk(8'h1d, top_exp());
            rchk(8'h1e, chan_exp());
        end
        {lim, inval} = 4'h0;
        idle(4);
        u_host.wr(8'h1b, 8'hff);
        rchk(8'h1b, 8'h00);
        for (int k = 0; k < 3; k++) for (int c = 0; c < 2; c++) begin
            ev = 8'h01 << (c * 4 + k);
            pulse(k, c, k == 1 ? 10 : 3);
            idle(4);
            rchk(8'h1b, ev);
            rchk(8'h19, 8'h20);
            u_host.wr(8'h1b, ev ^ 8'h77);
            rchk(8'h1b, ev);
            u_host.wr(8'h1b, ev);
            rchk(8'h1b, 8'h00);
            rchk(8'h19, 8'h00);
        end
        pulse(1, 0, 8);
        idle(4);
        rchk(8'h1b, 8'h00);
        pulse(0, 1, 3);
        idle(4);
        u_host.wr(8'h18, 8'h01);
        idle(4);
        rchk(8'h1b, 8'h00);
        rchk(8'h1a, 8'h01);
        rchk(8'h18, 8'h00);
        u_host.wr(8'h1a, 8'h01);
        rchk(8'h1a, 8'h00);
        uv = 1'h1;
        idle(4);
        chk("hold outputs", 8'h07, {5'h0, dis, rrst, srst});
        uv = 1'h0;
        idle(6);
        chk("run outputs", 8'h00, {5'h0, dis, rrst, srst});
        rchk(8'h1a, 8'h01);
        test_done();
    end
endmodule : dual_buck_event_status_bank_tb
